// ==== hw/irqf_defines.svh ====
// register indices, field positions, reset values and timing counts of the interrupt flag block
`ifndef IRQF_DEFINES_SVH
`define IRQF_DEFINES_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IRQF_IDX_REQ_LO  20'hF_FFE0
`define IRQF_IDX_REQ_HI  20'hF_FFE1
`define IRQF_IDX_MSK_LO  20'hF_FFE4
`define IRQF_IDX_MSK_HI  20'hF_FFE5
`define IRQF_IDX_PR0_LO  20'hF_FFE8
`define IRQF_IDX_PR0_HI  20'hF_FFE9
`define IRQF_IDX_PR1_LO  20'hF_FFEC
`define IRQF_IDX_PR1_HI  20'hF_FFED
`define IRQF_IDX_STAT    20'hF_FFF0
`define IRQF_IDX_SAVE    20'hF_FFF1
`define IRQF_IDX_BITOP   20'hF_FFF2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define IRQF_RST_REQ     8'h00
`define IRQF_RST_MSK     8'hFF
`define IRQF_RST_PR      8'hFF
`define IRQF_RST_IE      1'h0
`define IRQF_RST_ISP     2'h3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define IRQF_STAT_IE     7
`define IRQF_STAT_ISP_HI 2
`define IRQF_STAT_ISP_LO 1
`define IRQF_BITOP_BIT   2:0
`define IRQF_BITOP_VAL   3
`define IRQF_BITOP_TGT   6:4
`define IRQF_SHARED_BIT  3

// ------------------------------------------------------------
// timing and source count
// ------------------------------------------------------------
`define IRQF_WR_EXTRA    2
`define IRQF_NUM_SRC     11

`endif

// ==== hw/irqf_pkg.sv ====
// types shared by the interrupt flag block
package irqf_pkg;

    typedef enum logic [1:0] {
        IRQF_ST_IDLE  = 2'b01,
        IRQF_ST_STALL = 2'b10
    } irqf_bus_st_e;

    typedef struct packed {
        logic       valid;
        logic [3:0] index;
        logic [1:0] level;
    } irqf_grant_s;

    typedef struct packed {
        logic       ie;
        logic [1:0] isp;
    } irqf_status_s;

    typedef struct packed {
        logic       go;
        logic [2:0] id;
        logic [7:0] en;
        logic [7:0] val;
    } irqf_wr_s;

endpackage : irqf_pkg

// ==== hw/irqf_top.sv ====
// interrupt request, mask and priority flags with apb access and core acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "irqf_defines.svh"

module irqf_top
    import irqf_pkg::*;
#(
    parameter int NUM_SRC  = `IRQF_NUM_SRC,
    parameter int WR_EXTRA = `IRQF_WR_EXTRA
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rst_b,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output var  logic [31:0]         prdata,
    output var  logic                pready,
    output var  logic                pslverr,
    // request sources, one-cycle pulses
    input  wire logic [NUM_SRC-1:0]  src_event,
    input  wire logic                clocked_serial_done_irq,
    // processor core side
    output var  irqf_grant_s         irq_grant,
    input  wire logic                ack,
    input  wire logic                software_break_instr,
    input  wire logic                ret,
    output var  irqf_status_s        program_status_word
);

    localparam int CW = $clog2(WR_EXTRA + 1);
    localparam logic [15:0] VALID = 16'((32'h1 << NUM_SRC) - 1);
    if (NUM_SRC < 4 || NUM_SRC > 16) begin : g_bad_src
        $error("irqf_top: NUM_SRC must be 4..16");
    end
    if (WR_EXTRA < 1) begin : g_bad_extra
        $error("irqf_top: WR_EXTRA must be at least 1");
    end
    function automatic logic [31:0] byte_addr(input logic [19:0] idx);
        return {10'h000, idx, 2'b00};
    endfunction : byte_addr

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic       hit;
    logic       sel_arr;
    logic       sel_stat;
    logic       sel_save;
    logic       sel_bitop;
    logic [2:0] rid;
    always_comb begin
        hit       = 1'b1;
        sel_arr   = 1'b0;
        sel_stat  = 1'b0;
        sel_save  = 1'b0;
        sel_bitop = 1'b0;
        rid       = 3'h0;
        case (paddr)
            byte_addr(`IRQF_IDX_REQ_LO): begin sel_arr = 1'b1; rid = 3'h0; end
            byte_addr(`IRQF_IDX_REQ_HI): begin sel_arr = 1'b1; rid = 3'h1; end
            byte_addr(`IRQF_IDX_MSK_LO): begin sel_arr = 1'b1; rid = 3'h2; end
            byte_addr(`IRQF_IDX_MSK_HI): begin sel_arr = 1'b1; rid = 3'h3; end
            byte_addr(`IRQF_IDX_PR0_LO): begin sel_arr = 1'b1; rid = 3'h4; end
            byte_addr(`IRQF_IDX_PR0_HI): begin sel_arr = 1'b1; rid = 3'h5; end
            byte_addr(`IRQF_IDX_PR1_LO): begin sel_arr = 1'b1; rid = 3'h6; end
            byte_addr(`IRQF_IDX_PR1_HI): begin sel_arr = 1'b1; rid = 3'h7; end
            byte_addr(`IRQF_IDX_STAT):   sel_stat  = 1'b1;
            byte_addr(`IRQF_IDX_SAVE):   sel_save  = 1'b1;
            byte_addr(`IRQF_IDX_BITOP):  sel_bitop = 1'b1;
            default:                     hit       = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // bus handshake with write stretch
    // ------------------------------------------------------------
    irqf_bus_st_e bus_st_q;
    irqf_bus_st_e bus_st_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          access;
    logic          slow;
    logic          commit;
    assign access = psel & penable;
    // flag stores are slowed so software timing matches the core's
    assign slow   = pwrite & (sel_arr | sel_bitop);
    always_comb begin
        bus_st_d = bus_st_q;
        cnt_d    = cnt_q;
        pready   = 1'b0;
        case (bus_st_q)
            IRQF_ST_IDLE: begin
                if (access) begin
                    if (slow) begin
                        bus_st_d = IRQF_ST_STALL;
                        cnt_d    = CW'(WR_EXTRA - 1);
                    end else begin
                        pready = 1'b1;
                    end
                end
            end
            IRQF_ST_STALL: begin
                if (cnt_q == '0) begin
                    pready   = access;
                    bus_st_d = IRQF_ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: bus_st_d = IRQF_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bus_st_q <= IRQF_ST_IDLE;
            cnt_q    <= '0;
        end else begin
            bus_st_q <= bus_st_d;
            cnt_q    <= cnt_d;
        end
    end

    assign commit  = access & pready & pwrite;
    assign pslverr = access & pready & ~hit;

    // ------------------------------------------------------------
    // software write: whole byte or one bit
    // ------------------------------------------------------------
    irqf_wr_s wr;
    always_comb begin
        wr.go = commit & (sel_arr | sel_bitop);
        if (sel_bitop) begin
            // one bit only, so other flags raised meanwhile survive
            wr.id  = pwdata[`IRQF_BITOP_TGT];
            wr.en  = 8'h01 << pwdata[`IRQF_BITOP_BIT];
            wr.val = {8{pwdata[`IRQF_BITOP_VAL]}};
        end else begin
            wr.id  = rid;
            wr.en  = 8'hFF;
            wr.val = pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // flag storage: 0 request, 1 mask, 2 priority low, 3 priority high
    // ------------------------------------------------------------
    logic [15:0]  flag_q [4];
    logic [15:0]  flag_d [4];
    logic [15:0]  sw_val [4];
    logic [15:0]  set_vec;
    logic [15:0]  clr_vec;
    irqf_grant_s  grant_q;
    irqf_grant_s  grant_d;
    logic         ack_take;
    assign ack_take = ack & grant_q.valid;
    always_comb begin
        logic [15:0] en16;
        en16 = '0;
        for (int v = 0; v < 4; v++) begin
            en16 = '0;
            if (wr.go && wr.id[2:1] == 2'(v)) begin
                en16 = wr.id[0] ? {wr.en, 8'h00} : {8'h00, wr.en};
            end
            sw_val[v] = (flag_q[v] & ~en16) | ({wr.val, wr.val} & en16);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_src
            if (gi < NUM_SRC) begin : g_live
                if (gi == `IRQF_SHARED_BIT) begin : g_shared
                    assign set_vec[gi] = src_event[gi] | clocked_serial_done_irq;
                end else begin : g_plain
                    assign set_vec[gi] = src_event[gi];
                end
                assign clr_vec[gi] = ack_take && (grant_q.index == 4'(gi));
            end else begin : g_dead
                assign set_vec[gi] = 1'b0;
                assign clr_vec[gi] = 1'b0;
            end
        end
    endgenerate

    always_comb begin
        // a new event outranks both software and acknowledge clears
        flag_d[0] = (set_vec | (sw_val[0] & ~clr_vec)) & VALID;
        flag_d[1] = sw_val[1] | ~VALID;
        flag_d[2] = sw_val[2] | ~VALID;
        flag_d[3] = sw_val[3] | ~VALID;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flag_q[0] <= {`IRQF_RST_REQ, `IRQF_RST_REQ};
            flag_q[1] <= {`IRQF_RST_MSK, `IRQF_RST_MSK};
            flag_q[2] <= {`IRQF_RST_PR, `IRQF_RST_PR};
            flag_q[3] <= {`IRQF_RST_PR, `IRQF_RST_PR};
        end else begin
            for (int v = 0; v < 4; v++) begin
                flag_q[v] <= flag_d[v];
            end
        end
    end

    // ------------------------------------------------------------
    // arbitration: lowest level first, then lowest index
    // ------------------------------------------------------------
    irqf_status_s st_q;
    irqf_status_s st_d;
    irqf_status_s save_q;
    irqf_status_s save_d;
    always_comb begin
        logic [1:0] lvl;
        lvl     = 2'h0;
        grant_d = '0;
        grant_d.level = 2'h3;
        for (int i = 0; i < NUM_SRC; i++) begin
            lvl = {flag_q[3][i], flag_q[2][i]};
            // masked requests are skipped but their flags stay set
            if (flag_q[0][i] && !flag_q[1][i] && st_q.ie && lvl <= st_q.isp) begin
                if (!grant_d.valid || lvl < grant_d.level) begin
                    grant_d.valid = 1'b1;
                    grant_d.index = 4'(i);
                    grant_d.level = lvl;
                end
            end
        end
        // drop the offer at once so one request is never taken twice
        if (ack_take) begin
            grant_d.valid = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            grant_q <= '0;
        end else begin
            grant_q <= grant_d;
        end
    end
    assign irq_grant = grant_q;

    // ------------------------------------------------------------
    // status word: global enable and in-service level
    // ------------------------------------------------------------
    always_comb begin
        st_d   = st_q;
        save_d = save_q;
        if (commit && sel_stat) begin
            st_d.ie  = pwdata[`IRQF_STAT_IE];
            st_d.isp = {pwdata[`IRQF_STAT_ISP_HI], pwdata[`IRQF_STAT_ISP_LO]};
        end
        if (ret) begin
            st_d = save_q;
        end
        if (ack_take) begin
            save_d  = st_q;
            st_d.ie = 1'b0;
            st_d.isp = grant_q.level;
        end else if (software_break_instr) begin
            save_d  = st_q;
            st_d.ie = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= '{ie: `IRQF_RST_IE, isp: `IRQF_RST_ISP};
            save_q <= '{ie: `IRQF_RST_IE, isp: `IRQF_RST_ISP};
        end else begin
            st_q   <= st_d;
            save_q <= save_d;
        end
    end

    assign program_status_word = st_q;

    // ------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    always_comb begin
        logic [7:0] rd;
        rd = 8'h00;
        if (sel_arr) begin
            // fixed upper bits come straight from storage (0 or 1)
            rd = rid[0] ? flag_q[rid[2:1]][15:8] : flag_q[rid[2:1]][7:0];
        end else if (sel_stat) begin
            rd = {st_q.ie, 4'h0, st_q.isp, 1'b0};
        end else if (sel_save) begin
            rd = {save_q.ie, 4'h0, save_q.isp, 1'b0};
        end
        prdata_d = (psel && !penable) ? {24'h00_0000, rd} : prdata_q;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0000_0000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;

endmodule : irqf_top

`default_nettype wire

// ==== verif/irqf_core_model.sv ====
// core stand-in that acknowledges offered requests, promptly or after a stall
`timescale 1ns/1ps
`default_nettype none
module irqf_core_model
    import irqf_pkg::*;
(
    // clock, reset, offer and answer
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire irqf_grant_s irq_grant,
    input  wire logic        slow,
    output var  logic        ack
);
    logic [1:0] wait_q;
    logic [1:0] wait_d;
    logic       ack_d;
    // never acks twice in a row: the offer drops only one cycle after the ack is taken
    always_comb begin
        wait_d = 2'h0;
        ack_d  = 1'b0;
        if (irq_grant.valid && !ack) begin
            if (slow && wait_q != 2'h3) begin
                wait_d = wait_q + 2'h1;
            end else begin
                ack_d = 1'b1;
            end
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 2'h0;
            ack    <= 1'b0;
        end else begin
            wait_q <= wait_d;
            ack    <= ack_d;
        end
    end
endmodule : irqf_core_model
`default_nettype wire

// ==== verif/irqf_top_asserts.sv ====
// port-level checks of the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module irqf_top_asserts
    import irqf_pkg::*;
#(
    parameter int NUM_SRC  = 11,
    parameter int WR_EXTRA = 2
) (
    // clock, reset and apb
    input wire logic         clock,
    input wire logic         rst_b,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [31:0]  paddr,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    // core side
    input wire irqf_grant_s  irq_grant,
    input wire logic         ack,
    input wire logic         software_break_instr,
    input wire irqf_status_s program_status_word
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------
    sequence s_taken;
        ack && irq_grant.valid;
    endsequence
    sequence s_flag_wr;
        psel && !penable && pwrite && paddr inside {32'h003F_FF80, 32'h003F_FF90};
    endsequence
    // the wait count is written for the default stretch of two
    sequence s_two_waits;
        (penable && !pready)[*2] ##1 (penable && pready);
    endsequence
    property p_wr_stretch; s_flag_wr |=> s_two_waits; endproperty
    a_wr_stretch: assert property (p_wr_stretch) else $error("flag write not stretched");
    property p_ack_drop; s_taken |=> !irq_grant.valid; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("offer stands after ack");
    property p_ack_ie; s_taken |=> !program_status_word.ie; endproperty
    a_ack_ie: assert property (p_ack_ie) else $error("enable kept after ack");
    property p_ack_isp; s_taken |=> program_status_word.isp == $past(irq_grant.level); endproperty
    a_ack_isp: assert property (p_ack_isp) else $error("level not copied");
    property p_brk_ie; software_break_instr |=> !program_status_word.ie; endproperty
    a_brk_ie: assert property (p_brk_ie) else $error("enable kept after break");
    property p_ie_gate; (!program_status_word.ie)[*2] |-> !irq_grant.valid; endproperty
    a_ie_gate: assert property (p_ie_gate) else $error("offer while disabled");
    property p_rqh_zero; psel && penable && pready && !pwrite && paddr == 32'h003F_FF84 |-> prdata[7:3] == 5'h00;
    endproperty
    a_rqh_zero: assert property (p_rqh_zero) else $error("request fixed bits set");
    property p_mkh_ones; psel && penable && pready && !pwrite && paddr == 32'h003F_FF94 |-> prdata[7:3] == 5'h1F;
    endproperty
    a_mkh_ones: assert property (p_mkh_ones) else $error("mask fixed bits clear");
endmodule : irqf_top_asserts
`default_nettype wire

// ==== verif/test_irqf_top.sv ====
// self-checking bench of the interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module test_irqf_top
    import irqf_pkg::*;
;
    typedef struct {
        logic [31:0] a;
        logic [7:0]  d;
        logic [7:0]  q;
        logic        e;
    } irqf_row_s;
    localparam logic [31:0] ad_rql = 32'h003F_FF80;
    localparam logic [31:0] ad_rqh = 32'h003F_FF84;
    localparam logic [31:0] ad_mkl = 32'h003F_FF90;
    localparam logic [31:0] ad_mkh = 32'h003F_FF94;
    localparam logic [31:0] ad_g1l = 32'h003F_FFB0;
    localparam logic [31:0] ad_g1h = 32'h003F_FFB4;
    localparam logic [31:0] ad_st  = 32'h003F_FFC0;
    localparam logic [31:0] ad_sv  = 32'h003F_FFC4;
    localparam logic [31:0] ad_bit = 32'h003F_FFC8;
    logic         clock = 1'b0;
    logic         rst_b = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [31:0]  paddr = 32'h0000_0000;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [10:0]  src_event = 11'h000;
    logic         clocked_serial_done_irq = 1'b0;
    logic         software_break_instr = 1'b0;
    logic         ret = 1'b0;
    logic         ack;
    logic         slow = 1'b0;
    irqf_grant_s  irq_grant;
    irqf_status_s program_status_word;
    logic [31:0]  rd;
    logic [7:0]   lo_v;
    logic         err;
    logic [3:0]   last_idx = 4'h0;
    int           acks = 0;
    int           miscompares = 0;
    int           tests_run = 0;
    // fixed upper bits are written with their read value
    // the last rows leave every source masked again
    irqf_row_s rows [9] = '{
        '{ad_rql, 8'hA5, 8'hA5, 1'b0}, '{ad_rqh, 8'h07, 8'h07, 1'b0}, '{ad_mkl, 8'h3C, 8'h3C, 1'b0},
        '{ad_mkh, 8'hF8, 8'hF8, 1'b0}, '{32'h003F_FFD0, 8'h00, 8'h00, 1'b1}, '{ad_rql, 8'h00, 8'h00, 1'b0},
        '{ad_rqh, 8'h00, 8'h00, 1'b0}, '{ad_mkh, 8'hFF, 8'hFF, 1'b0}, '{ad_mkl, 8'hFF, 8'hFF, 1'b0}
    };
    irqf_top irqf_top_inst (
        .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src_event,
        .clocked_serial_done_irq, .irq_grant, .ack, .software_break_instr, .ret, .program_status_word
    );
    irqf_core_model irqf_core_model_inst (.clock, .rst_b, .irq_grant, .slow, .ack);
    always #25 clock = ~clock;
    always @(posedge clock) begin
        if (ack === 1'b1 && irq_grant.valid === 1'b1) begin
            acks     <= acks + 1;
            last_idx <= irq_grant.index;
        end
    end
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        // pready and the answer are taken at the very edge that completes the access
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rdc
    // bit 13 break, 12 return, 11 clocked serial, 10:0 sources
    task automatic pulse(input logic [13:0] m);
        @(posedge clock);
        {software_break_instr, ret, clocked_serial_done_irq, src_event} <= m;
        @(posedge clock);
        {software_break_instr, ret, clocked_serial_done_irq, src_event} <= 14'h0000;
    endtask : pulse
    task automatic serve(input logic [3:0] idx, input logic [7:0] st);
        int k;
        int n;
        k = acks;
        n = 0;
        while (acks == k && n < 60) begin
            @(negedge clock);
            n++;
        end
        if (acks == k) begin
            miscompares++;
            tally_and_finish();
        end
        check({28'h0, last_idx}, {28'h0, idx});
        rdc(ad_st, {24'h0, st});
    endtask : serve
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        rdc(ad_rql, 32'h0000_0000);
        rdc(ad_rqh, 32'h0000_0000);
        rdc(ad_mkl, 32'h0000_00FF);
        rdc(ad_mkh, 32'h0000_00FF);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, {24'h0, rows[i].d});
            bus(1'b0, rows[i].a, 32'h0000_0000);
            check({23'h0, err, rd[7:0] & {8{!rows[i].e}}}, {23'h0, rows[i].e, rows[i].q});
        end
        for (int i = 0; i < 11; i++) begin
            pulse(14'(1 << i));
            bus(1'b0, ad_rql, 32'h0000_0000);
            lo_v = rd[7:0];
            bus(1'b0, ad_rqh, 32'h0000_0000);
            check({16'h0000, rd[7:0], lo_v}, 32'h1 << i);
            // single-bit clear: target register in bits 6:4, bit number in bits 2:0
            bus(1'b1, ad_bit, 32'((i / 8) * 16 + i % 8));
        end
        rdc(ad_rqh, 32'h0000_0000);
        pulse(14'h0800);
        rdc(ad_rql, 32'h0000_0008);
        bus(1'b1, ad_bit, 32'h0000_000E);
        rdc(ad_rql, 32'h0000_0048);
        // a source event lands in the cycle that completes a bit clear
        fork
            bus(1'b1, ad_bit, 32'h0000_0006);
            begin
                repeat (4) @(posedge clock);
                src_event <= 11'h040;
                @(posedge clock);
                src_event <= 11'h000;
            end
        join
        rdc(ad_rql, 32'h0000_0048);
        bus(1'b1, ad_bit, 32'h0000_0006);
        bus(1'b1, ad_bit, 32'h0000_0003);
        rdc(ad_rql, 32'h0000_0000);
        pulse(14'h0012);
        bus(1'b1, ad_st, 32'h0000_0086);
        repeat (10) @(posedge clock);
        check(32'(acks), 32'h0000_0000);
        rdc(ad_rql, 32'h0000_0012);
        bus(1'b1, ad_g1l, 32'h0000_00EF);
        bus(1'b1, ad_mkl, 32'h0000_0000);
        serve(4'h4, 8'h02);
        rdc(ad_rql, 32'h0000_0002);
        pulse(14'h1000);
        serve(4'h1, 8'h06);
        slow <= 1'b1;
        pulse(14'h0024);
        pulse(14'h1000);
        serve(4'h2, 8'h06);
        pulse(14'h1000);
        serve(4'h5, 8'h06);
        pulse(14'h1000);
        rdc(ad_st, 32'h0000_0086);
        pulse(14'h2000);
        rdc(ad_st, 32'h0000_0006);
        rdc(ad_sv, 32'h0000_0086);
        // single-bit set of mask bit 0 through the bit-op register
        bus(1'b1, ad_bit, 32'h0000_0028);
        rdc(ad_mkl, 32'h0000_0001);
        tally_and_finish();
    end
endmodule : test_irqf_top
bind irqf_top irqf_top_asserts #(.NUM_SRC(NUM_SRC), .WR_EXTRA(WR_EXTRA)) irqf_top_asserts_inst (
    .clock, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .irq_grant, .ack,
    .software_break_instr, .program_status_word
);
`default_nettype wire
